// >>> sms_pkg.sv
// Notes on behaviour
// - Send byte: address write, one byte, both acked
// - Write byte: command sets pointer, data stored there
// - Read byte after command; receive byte skips command
// - Block write: command, count, count data bytes
// - Block read: count then data, master NACKs last
// - ACK is SDA low at SCL rise
// - All bits sampled on SCL rising edges
// - Write PEC byte follows last data, acked
// - Read PEC byte sent after last data
// - Alert driven only when enabled and pin assigned
// - Alert pin open drain, only pulls low
// - Fault pulls alert pin low
// - Alert response: ack, return own address, release
// - Alert source flag set; write one clears
// - Pin assigned but alert disabled: fault output
// - Only one host port active; busy means own address NACKed
// - Invalid command address NACKed, pointer kept
// - Block pointer saturates at 8Fh or FFh
// - Block read always reports sixteen bytes
// - Write PEC acked only when it matches
package sms_pkg;
  localparam logic [6:0] ARA_ADDR   = 7'h0C;
  localparam logic [7:0] BLK_WR_CMD = 8'h94;
  localparam logic [7:0] BLK_RD_CMD = 8'h95;
  localparam logic [7:0] CFG_TOP    = 8'h8F;
  localparam logic [7:0] UF_BASE    = 8'hC0;
  localparam logic [7:0] UF_TOP     = 8'hFF;
  localparam logic [7:0] BLK_MAX    = 8'h10;
  localparam logic [7:0] FLAG_ADDR  = 8'h1C;
  localparam int         FLAG_BIT   = 7;
  localparam logic [7:0] CRC_POLY   = 8'h07;
  localparam logic [7:0] CRC_INIT   = 8'h00;
  localparam logic [2:0] BIT_LAST   = 3'h7;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} sms_state_t;
  typedef enum logic [2:0] {RK_ADDR, RK_CMD, RK_CNT, RK_DATA, RK_PEC, RK_NONE} sms_rx_kind_t;
  typedef enum logic [1:0] {TK_ARA, TK_CNT, TK_DATA, TK_PEC} sms_tx_kind_t;

  typedef struct packed {
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
  } sms_mem_req_t;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
    end
    return x;
  endfunction

  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    return (p == CFG_TOP || p == UF_TOP) ? p : 8'(p + 8'h01);
  endfunction

  function automatic logic addr_valid(input logic [7:0] a);
    return (a <= CFG_TOP) || (a >= UF_BASE);
  endfunction
endpackage

// >>> sms_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sms_sync
  import sms_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule
`default_nettype wire

// >>> sms_mem.sv
`timescale 1ns/100ps
`default_nettype none
module sms_mem
  import sms_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic       re,
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata_r
);
  logic [7:0] mem [256];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata_r <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// >>> sms_smbus_slave.sv
`timescale 1ns/100ps
`default_nettype none
module sms_smbus_slave
  import sms_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h50
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n,
  input  wire logic fault_active,
  input  wire logic jtag_busy,
  input  wire logic pec_enable,
  input  wire logic alert_enable_bit,
  input  wire logic gp1_alert_mode,
  output logic      first_general_pin_o,
  output logic      first_general_pin_oe_n,
  output logic      alert_source_flag,
  output logic      alert_pending
);
  // Link reset: set with srst, released on SCL
  logic lrst_a_r, lrst_r;
  always_ff @(posedge scl_i or posedge srst) begin
    if (srst) begin
      lrst_a_r <= 1'b1;
      lrst_r   <= 1'b1;
    end else begin
      lrst_a_r <= 1'b0;
      lrst_r   <= lrst_a_r;
    end
  end

  // Start and stop seen on SDA edges while SCL high
  logic stop_tgl_r, start_tgl_r, fresh_r, stop_seen_r;
  always_ff @(posedge sda_i or posedge srst) begin
    if (srst) begin
      stop_tgl_r <= 1'b0;
    end else if (scl_i) begin
      stop_tgl_r <= ~stop_tgl_r;
    end
  end
  always_ff @(negedge sda_i or posedge srst) begin
    if (srst) begin
      start_tgl_r <= 1'b0;
      fresh_r     <= 1'b0;
      stop_seen_r <= 1'b1;
    end else if (scl_i) begin
      start_tgl_r <= ~start_tgl_r;
      fresh_r     <= stop_tgl_r != stop_seen_r;
      stop_seen_r <= stop_tgl_r;
    end
  end

  // Link engine state
  sms_state_t   st_r;
  sms_rx_kind_t rk_r;
  sms_tx_kind_t tk_r;
  logic [2:0]   bit_r;
  logic [7:0]   sh_r, tx_sh_r, tx_byte_r, byte_r, ptr_r, crc_r;
  logic [4:0]   left_r;
  logic         ack_r, rw_r, ara_r, blk_wr_r, blk_rd_r;
  logic         req_tgl_r, ara_tgl_r, start_mark_r, start_pend_r;
  sms_mem_req_t req_r;
  logic [2:0]   lsync;
  logic [7:0]   rd_hold_r;

  sms_sync #(.W(3)) u_lsync (
    .clk (scl_i),
    .d   ({jtag_busy, pec_enable, alert_pending}),
    .q   (lsync)
  );
  wire jtag_s  = lsync[2];
  wire pec_s   = lsync[1];
  wire alert_s = lsync[0];

  // Byte decode
  wire [7:0] rx_byte   = {sh_r[6:0], sda_i};
  wire       addr_self = rx_byte[7:1] == SLAVE_ADDR && !jtag_s;
  wire       addr_ara  = rx_byte[7:1] == ARA_ADDR && rx_byte[0] && alert_s;
  wire       cmd_blk   = rx_byte == BLK_WR_CMD || rx_byte == BLK_RD_CMD;
  wire       cmd_ok    = cmd_blk || addr_valid(rx_byte);
  wire       cnt_ok    = rx_byte != 8'h00 && rx_byte <= BLK_MAX;
  wire       pec_ok    = pec_s && rx_byte == crc_r;
  wire [7:0] crc_rx    = crc8(crc_r, rx_byte);
  wire [7:0] crc_tx    = crc8(crc_r, tx_byte_r);
  wire [7:0] ptr_adv   = ptr_next(ptr_r);
  wire       rx_done   = st_r == ST_RX && bit_r == BIT_LAST;
  wire       more_blk  = blk_wr_r && left_r > 5'h01;

  wire ack_nxt = (rk_r == RK_ADDR) ? (addr_self || addr_ara) :
                 (rk_r == RK_CMD)  ? cmd_ok :
                 (rk_r == RK_CNT)  ? cnt_ok :
                 (rk_r == RK_DATA) ? 1'b1 :
                 (rk_r == RK_PEC)  ? pec_ok : 1'b0;

  wire sms_rx_kind_t after_data = pec_s ? RK_PEC : RK_NONE;
  wire sms_rx_kind_t rk_nxt =
    (rk_r == RK_ADDR) ? RK_CMD :
    (rk_r == RK_CMD)  ? ((rx_byte == BLK_WR_CMD) ? RK_CNT :
                         (rx_byte == BLK_RD_CMD) ? RK_NONE : RK_DATA) :
    (rk_r == RK_CNT)  ? RK_DATA :
    (rk_r == RK_DATA) ? (more_blk ? RK_DATA : after_data) : RK_NONE;

  // First byte after the read address
  wire sms_tx_kind_t tk_first = ara_r ? TK_ARA : blk_rd_r ? TK_CNT : TK_DATA;
  wire [7:0] tx_first = ara_r ? {SLAVE_ADDR, 1'b0} :
                        blk_rd_r ? BLK_MAX : rd_hold_r;
  wire blk_more_rd = blk_rd_r && left_r > 5'h01;
  wire to_data = tk_r == TK_CNT || (tk_r == TK_DATA && blk_more_rd);
  wire to_pec  = pec_s && (tk_r == TK_DATA) && !blk_more_rd;

  // Only drives low: ACK slot or a zero data bit
  wire drive_low = (st_r == ST_RX_ACK && ack_r) ||
                   (st_r == ST_TX && !tx_sh_r[7]);

  always_ff @(negedge scl_i or posedge srst) begin
    if (srst) begin
      start_mark_r <= 1'b0;
      start_pend_r <= 1'b0;
      sda_oe_n     <= 1'b1;
      sda_o        <= 1'b0;
    end else begin
      start_mark_r <= start_tgl_r;
      start_pend_r <= start_tgl_r != start_mark_r;
      sda_oe_n     <= !(drive_low && start_tgl_r == start_mark_r);
      sda_o        <= 1'b0;
    end
  end

  // Bits sampled and shifted on SCL rise
  always_ff @(posedge scl_i) begin
    if (lrst_r) begin
      st_r      <= ST_IDLE;
      rk_r      <= RK_NONE;
      tk_r      <= TK_DATA;
      bit_r     <= 3'h0;
      sh_r      <= 8'h00;
      tx_sh_r   <= 8'hFF;
      tx_byte_r <= 8'hFF;
      byte_r    <= 8'h00;
      ptr_r     <= 8'h00;
      crc_r     <= CRC_INIT;
      left_r    <= 5'h00;
      ack_r     <= 1'b0;
      rw_r      <= 1'b0;
      ara_r     <= 1'b0;
      blk_wr_r  <= 1'b0;
      blk_rd_r  <= 1'b0;
      req_tgl_r <= 1'b0;
      ara_tgl_r <= 1'b0;
      req_r     <= '0;
    end else if (start_pend_r) begin
      st_r  <= ST_RX;
      rk_r  <= RK_ADDR;
      bit_r <= 3'h1;
      sh_r  <= {7'h00, sda_i};
      if (fresh_r) begin
        crc_r    <= CRC_INIT;
        blk_wr_r <= 1'b0;
        blk_rd_r <= 1'b0;
      end
    end else begin
      unique case (st_r)
        ST_IDLE: begin
        end
        ST_RX: begin
          sh_r  <= rx_byte;
          bit_r <= 3'(bit_r + 3'h1);
          if (rx_done) begin
            st_r   <= ST_RX_ACK;
            ack_r  <= ack_nxt;
            crc_r  <= crc_rx;
            byte_r <= rx_byte;
            rk_r   <= rk_nxt;
            if (rk_r == RK_ADDR) begin
              rw_r  <= rx_byte[0];
              ara_r <= addr_ara && !addr_self;
            end
            if (rk_r == RK_CMD && cmd_ok) begin
              blk_wr_r <= rx_byte == BLK_WR_CMD;
              blk_rd_r <= rx_byte == BLK_RD_CMD;
              if (!cmd_blk) begin
                ptr_r     <= rx_byte;
                req_r     <= '{wr_en: 1'b0, wr_addr: ptr_r, wr_data: 8'h00, rd_addr: rx_byte};
                req_tgl_r <= ~req_tgl_r;
              end
            end
            if (rk_r == RK_CNT && cnt_ok) begin
              left_r <= rx_byte[4:0];
            end
            if (rk_r == RK_DATA) begin
              req_r     <= '{wr_en: 1'b1, wr_addr: ptr_r, wr_data: rx_byte,
                             rd_addr: blk_wr_r ? ptr_adv : ptr_r};
              req_tgl_r <= ~req_tgl_r;
              if (blk_wr_r) begin
                ptr_r  <= ptr_adv;
                left_r <= 5'(left_r - 5'h01);
              end
            end
          end
        end
        ST_RX_ACK: begin
          bit_r <= 3'h0;
          if (!ack_r) begin
            st_r <= ST_IDLE;
          end else if (rw_r && rk_r == RK_CMD) begin
            st_r      <= ST_TX;
            tk_r      <= tk_first;
            tx_sh_r   <= tx_first;
            tx_byte_r <= tx_first;
            left_r    <= BLK_MAX[4:0];
          end else begin
            st_r <= ST_RX;
          end
        end
        ST_TX: begin
          tx_sh_r <= {tx_sh_r[6:0], 1'b1};
          bit_r   <= 3'(bit_r + 3'h1);
          if (bit_r == BIT_LAST) begin
            st_r  <= ST_TX_ACK;
            crc_r <= crc_tx;
            if (tk_r == TK_ARA) begin
              ara_tgl_r <= ~ara_tgl_r;
            end
          end
        end
        ST_TX_ACK: begin
          if (sda_i || !(to_data || to_pec)) begin
            st_r <= ST_IDLE;
          end else if (to_data) begin
            st_r      <= ST_TX;
            tk_r      <= TK_DATA;
            tx_sh_r   <= rd_hold_r;
            tx_byte_r <= rd_hold_r;
            if (tk_r == TK_DATA) begin
              left_r <= 5'(left_r - 5'h01);
            end
            if (blk_rd_r) begin
              ptr_r     <= ptr_adv;
              req_r     <= '{wr_en: 1'b0, wr_addr: ptr_r, wr_data: 8'h00, rd_addr: ptr_adv};
              req_tgl_r <= ~req_tgl_r;
            end
          end else begin
            st_r      <= ST_TX;
            tk_r      <= TK_PEC;
            tx_sh_r   <= crc_r;
            tx_byte_r <= crc_r;
          end
        end
      endcase
    end
  end

  // Core side: memory requests, alert and flag
  logic [1:0] csync;
  logic       req_d_r, ara_d_r, re_r, load_r, fault_d_r;
  logic [7:0] mem_q;

  sms_sync #(.W(2)) u_csync (
    .clk (clk),
    .d   ({req_tgl_r, ara_tgl_r}),
    .q   (csync)
  );

  wire req_evt    = csync[1] ^ req_d_r;
  wire ara_evt    = csync[0] ^ ara_d_r;
  wire fault_rise = fault_active && !fault_d_r;
  wire flag_clr   = req_evt && req_r.wr_en && req_r.wr_addr == FLAG_ADDR &&
                    req_r.wr_data[FLAG_BIT];
  wire alert_set  = fault_rise && alert_enable_bit && gp1_alert_mode;
  wire pin_low    = gp1_alert_mode &&
                    (alert_enable_bit ? alert_pending : fault_active);
  wire [7:0] rd_view = (req_r.rd_addr == FLAG_ADDR) ?
                       {alert_source_flag, mem_q[6:0]} : mem_q;

  sms_mem u_mem (
    .clk     (clk),
    .we      (req_evt && req_r.wr_en),
    .waddr   (req_r.wr_addr),
    .wdata   (req_r.wr_data),
    .re      (re_r),
    .raddr   (req_r.rd_addr),
    .rdata_r (mem_q)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      req_d_r                <= 1'b0;
      ara_d_r                <= 1'b0;
      re_r                   <= 1'b0;
      load_r                 <= 1'b0;
      fault_d_r              <= 1'b0;
      rd_hold_r              <= 8'h00;
      alert_pending          <= 1'b0;
      alert_source_flag      <= 1'b0;
      first_general_pin_o    <= 1'b0;
      first_general_pin_oe_n <= 1'b1;
    end else begin
      req_d_r   <= csync[1];
      ara_d_r   <= csync[0];
      re_r      <= req_evt;
      load_r    <= re_r;
      fault_d_r <= fault_active;
      if (load_r) begin
        rd_hold_r <= rd_view;
      end
      // Set wins over clear
      alert_pending          <= alert_set || (alert_pending && !ara_evt);
      alert_source_flag      <= fault_rise || (alert_source_flag && !flag_clr);
      first_general_pin_o    <= 1'b0;
      first_general_pin_oe_n <= !pin_low;
    end
  end

  // Checks
  sequence fault_rise_s;
    fault_active && !fault_d_r && alert_enable_bit && gp1_alert_mode;
  endsequence
  sequence pin_pulls_s;
    ##2 !first_general_pin_oe_n;
  endsequence

  pin_low_only_a: assert property (@(posedge clk) disable iff (srst)
    !first_general_pin_oe_n |-> !first_general_pin_o)
    else $error("pin driven high");
  pin_gate_a: assert property (@(posedge clk) disable iff (srst)
    !first_general_pin_oe_n |-> $past(gp1_alert_mode))
    else $error("pin driven without alert mode");
  fault_alert_a: assert property (@(posedge clk) disable iff (srst)
    fault_rise_s ##0 (!ara_evt)[*2] |-> pin_pulls_s)
    else $error("alert not raised after fault");
  flag_set_a: assert property (@(posedge clk) disable iff (srst)
    fault_rise |=> alert_source_flag)
    else $error("alert flag not set");
  fault_out_a: assert property (@(posedge clk) disable iff (srst)
    gp1_alert_mode && !alert_enable_bit && fault_active |=> !first_general_pin_oe_n)
    else $error("fault output not driven");
  ack_drive_a: assert property (@(posedge scl_i) disable iff (lrst_r)
    st_r == ST_RX_ACK && ack_r && !start_pend_r |-> !sda_oe_n)
    else $error("ACK slot not driven low");
  bad_cmd_a: assert property (@(posedge scl_i) disable iff (lrst_r)
    rx_done && rk_r == RK_CMD && !cmd_ok && !start_pend_r |=> !ack_r && ptr_r == $past(ptr_r))
    else $error("invalid command changed pointer");
  ptr_sat_a: assert property (@(posedge scl_i) disable iff (lrst_r)
    $past(ptr_r) == CFG_TOP |-> ptr_r != 8'h90)
    else $error("pointer passed configuration top");
  blk_count_a: assert property (@(posedge scl_i) disable iff (lrst_r)
    st_r == ST_TX && tk_r == TK_CNT |-> tx_byte_r == BLK_MAX)
    else $error("block count not sixteen");
  ara_byte_a: assert property (@(posedge scl_i) disable iff (lrst_r)
    st_r == ST_TX && tk_r == TK_ARA |-> tx_byte_r == {SLAVE_ADDR, 1'b0})
    else $error("alert response byte wrong");
  pec_check_a: assert property (@(posedge scl_i) disable iff (lrst_r)
    rx_done && rk_r == RK_PEC && !start_pend_r |=> ack_r == (pec_s && byte_r == $past(crc_r)))
    else $error("PEC acknowledge wrong");
endmodule
`default_nettype wire

// >>> sms_host.sv
`timescale 1ns/100ps
`default_nettype none
module sms_host (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // One bit, sampled at the rising edge
  task automatic bit_x(input logic b, output logic r);
    #3.75 sda_m = b;
    #3.75 scl = 1'b1;
    r = sda;
    #7.5 scl = 1'b0;
  endtask

  // Start, also used as repeated start
  task automatic start();
    #3.75 sda_m = 1'b1;
    #3.75 scl = 1'b1;
    #3.75 sda_m = 1'b0;
    #3.75 scl = 1'b0;
  endtask

  task automatic stop();
    #3.75 sda_m = 1'b0;
    #3.75 scl = 1'b1;
    #3.75 sda_m = 1'b1;
    #7.5;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(~ack, r);
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import sms_pkg::*;
;
  localparam logic [6:0] SA = 7'h50;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       fault_active = 1'b0;
  logic       jtag_busy = 1'b0;
  logic       pec_enable = 1'b0;
  logic       alert_enable_bit = 1'b0;
  logic       gp1_alert_mode = 1'b0;
  logic       scl, sda_m, sda_o, sda_oe_n, gp_o, gp_oe_n, flag, pending;
  wire        sda;
  logic [7:0] mem [256];
  logic [7:0] crc, ptr;
  int         n_errors = 0;
  int         cmp_count = 0;

  assign sda = sda_m & (sda_oe_n | sda_o);
  always #2.5 clk = ~clk;

  sms_smbus_slave #(.SLAVE_ADDR(SA)) dut (
    .clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .fault_active(fault_active), .jtag_busy(jtag_busy), .pec_enable(pec_enable),
    .alert_enable_bit(alert_enable_bit), .gp1_alert_mode(gp1_alert_mode),
    .first_general_pin_o(gp_o), .first_general_pin_oe_n(gp_oe_n),
    .alert_source_flag(flag), .alert_pending(pending)
  );
  sms_host host (.scl(scl), .sda_m(sda_m), .sda(sda));

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk1(input string what, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    end
    return x;
  endfunction

  function automatic logic [7:0] nxt(input logic [7:0] p);
    return (p == 8'h8F || p == 8'hFF) ? p : p + 8'h01;
  endfunction

  function automatic logic [7:0] rnd_addr();
    logic [7:0] a;
    a = 8'($urandom);
    if (a inside {[8'h90:8'hBF]}) begin
      a = a ^ 8'h40;
    end
    return (a == 8'h1C) ? 8'h1D : a;
  endfunction

  task automatic put(input logic [7:0] d, input logic ack, input string what);
    logic a;
    host.wr_byte(d, a);
    crc = crc_step(crc, d);
    chk1(what, ack, a);
  endtask

  task automatic get(input logic ack, input logic [7:0] e, input string what);
    logic [7:0] d;
    host.rd_byte(ack, d);
    crc = crc_step(crc, d);
    chk8(what, e, d);
  endtask

  task automatic open_tx(input logic [6:0] a, input logic rw, input logic ack);
    host.start();
    put({a, rw}, ack, "address");
  endtask

  task automatic send(input logic [7:0] a);
    crc = 8'h00;
    open_tx(SA, 1'b0, 1'b1);
    put(a, 1'b1, "send byte");
    host.stop();
    ptr = a;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bad);
    crc = 8'h00;
    open_tx(SA, 1'b0, 1'b1);
    put(a, 1'b1, "command");
    put(d, 1'b1, "data");
    if (pec_enable) begin
      put(crc ^ {7'h00, bad}, ~bad, "write pec");
    end
    host.stop();
    mem[a] = d;
    ptr = a;
  endtask

  task automatic rd(input logic [7:0] a, input logic cmd);
    crc = 8'h00;
    if (cmd) begin
      open_tx(SA, 1'b0, 1'b1);
      put(a, 1'b1, "command");
      ptr = a;
    end
    open_tx(SA, 1'b1, 1'b1);
    get(pec_enable, mem[a], "read data");
    if (pec_enable) begin
      get(1'b0, crc, "read pec");
    end
    host.stop();
  endtask

  task automatic blk_wr(input logic [7:0] a, input int n);
    logic [7:0] d;
    send(a);
    crc = 8'h00;
    open_tx(SA, 1'b0, 1'b1);
    put(BLK_WR_CMD, 1'b1, "block command");
    put(8'(n), 1'b1, "count");
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      put(d, 1'b1, "block data");
      mem[ptr] = d;
      ptr = nxt(ptr);
    end
    if (pec_enable) begin
      put(crc, 1'b1, "block pec");
    end
    host.stop();
  endtask

  task automatic blk_rd(input logic [7:0] a, input int n);
    send(a);
    open_tx(SA, 1'b0, 1'b1);
    put(BLK_RD_CMD, 1'b1, "block command");
    open_tx(SA, 1'b1, 1'b1);
    get(1'b1, BLK_MAX, "block count");
    for (int i = 0; i < n; i++) begin
      get(i < n - 1, mem[ptr], "block data");
      ptr = nxt(ptr);
    end
    host.stop();
  endtask

  task automatic wait_pin(input logic e);
    int k;
    k = 0;
    while (k < 20 && gp_oe_n !== e) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (gp_oe_n !== e) begin
      n_errors++;
      end_sim();
    end
  endtask

  initial begin
    logic [7:0] av [10];
    void'($urandom(32'h9266));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    crc = 8'h00;
    open_tx(7'h2A, 1'b0, 1'b0);
    host.stop();
    for (int i = 0; i < 10; i++) begin
      av[i] = rnd_addr();
      wr(av[i], 8'($urandom), 1'b0);
    end
    for (int i = 9; i >= 0; i--) begin
      rd(av[i], 1'b1);
      rd(av[i], 1'b0);
    end
    open_tx(SA, 1'b0, 1'b1);
    put(8'h96 + 8'($urandom % 42), 1'b0, "invalid command");
    host.stop();
    rd(ptr, 1'b0);
    for (int c = 0; c < 2; c++) begin
      open_tx(SA, 1'b0, 1'b1);
      put(BLK_WR_CMD, 1'b1, "block command");
      put(c ? 8'h11 : 8'h00, 1'b0, "bad count");
      host.stop();
    end
    @(posedge clk);
    jtag_busy <= 1'b1;
    open_tx(SA, 1'b0, 1'b0);
    host.stop();
    jtag_busy <= 1'b0;
    blk_wr(8'h8E, 3);
    rd(8'h8E, 1'b1);
    rd(8'h8F, 1'b1);
    blk_wr(UF_BASE, 16);
    blk_rd(UF_BASE, 5);
    blk_wr(8'hFD, 5);
    blk_rd(8'hFD, 3);
    @(posedge clk);
    pec_enable <= 1'b1;
    wr(av[0], 8'($urandom), 1'b0);
    wr(av[1], 8'($urandom), 1'b1);
    rd(av[0], 1'b1);
    rd(av[1], 1'b1);
    blk_wr(8'h40, 2);
    @(posedge clk);
    pec_enable <= 1'b0;
    alert_enable_bit <= 1'b1;
    gp1_alert_mode <= 1'b1;
    crc = 8'h00;
    open_tx(ARA_ADDR, 1'b1, 1'b0);
    host.stop();
    @(posedge clk);
    fault_active <= 1'b1;
    wait_pin(1'b0);
    chk1("alert pin", 1'b0, gp_oe_n);
    chk1("alert level", 1'b0, gp_o);
    chk1("alert flag", 1'b1, flag);
    chk1("alert pending", 1'b1, pending);
    fault_active <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk1("alert held", 1'b0, gp_oe_n);
    crc = 8'h00;
    open_tx(ARA_ADDR, 1'b1, 1'b1);
    get(1'b0, {SA, 1'b0}, "alert response");
    host.stop();
    wait_pin(1'b1);
    chk1("pending after response", 1'b0, pending);
    chk1("flag after response", 1'b1, flag);
    wr(FLAG_ADDR, 8'h00, 1'b0);
    repeat (10) @(posedge clk);
    #1;
    chk1("flag kept", 1'b1, flag);
    wr(FLAG_ADDR, 8'h80, 1'b0);
    repeat (10) @(posedge clk);
    #1;
    chk1("flag cleared", 1'b0, flag);
    alert_enable_bit <= 1'b0;
    fault_active <= 1'b1;
    wait_pin(1'b0);
    chk1("fault output", 1'b0, pending);
    fault_active <= 1'b0;
    wait_pin(1'b1);
    chk1("fault output off", 1'b1, gp_oe_n);
    alert_enable_bit <= 1'b1;
    gp1_alert_mode <= 1'b0;
    fault_active <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk1("pin unassigned", 1'b1, gp_oe_n);
    chk1("no pending", 1'b0, pending);
    end_sim();
  end
endmodule
`default_nettype wire
